// ### hw/frw_params.svh
`ifndef FRW_PARAMS_SVH
`define FRW_PARAMS_SVH
// register byte offsets on the apb side
`define FRW_AW 8
`define FRW_CFG_W 8
`define FRW_OFS_NVCFG 8'h00
`define FRW_OFS_VCFG 8'h04
`define FRW_OFS_CRCCTL 8'h08
`define FRW_OFS_LCRC 8'h0c
`define FRW_OFS_ACRC 8'h10
`define FRW_OFS_ESTAT 8'h14
// configuration field positions
`define FRW_B_DRV_HI 7
`define FRW_B_DRV_LO 5
`define FRW_B_WEN 4
`define FRW_B_ECC 3
`define FRW_B_SLP 2
`define FRW_B_WLEN_HI 1
`define FRW_B_WLEN_LO 0
// status and control field positions
`define FRW_B_DBL 4
`define FRW_B_SGL 3
`define FRW_B_CRCD 0
// reset values
`define FRW_CFG_FACTORY 8'ha8
`define FRW_LCRC_RST 32'hffffffff
`define FRW_ACRC_RST 32'h00000000
`define FRW_ZERO32 32'h00000000
`define FRW_SYNC_HI3 3'h7
`define FRW_SYNC_LO3 3'h0
`define FRW_SYNC_HI2 2'h3
// wrap group: smallest group in bytes, ecc unit as address shift
`define FRW_WRAP_BASE 7'h08
`define FRW_ONE7 7'h01
`define FRW_ONE32 32'h00000001
`define FRW_UNIT_SHIFT 4
`endif

// ### hw/frw_pkg.sv
`default_nettype none
package frw_pkg;
    typedef enum logic [1:0] {FRW_PWR_INIT, FRW_PWR_STBY, FRW_PWR_DPD} frw_pwr_type;
    typedef struct packed {
        logic [7:0] nv_cfg;
        logic [7:0] v_cfg;
        logic crc_dis;
        logic [31:0] lcrc;
        logic [31:0] acrc;
        logic dbl;
        logic sgl;
        frw_pwr_type pwr;
        logic [31:0] addr;
        logic burst;
        logic [2:0] sck_s;
        logic [2:0] cs_s;
        logic [1:0] hwr_s;
        logic [31:0] rdata;
    } frw_state_type;
endpackage
`default_nettype wire

// ### hw/frw_regs.sv
// Contract
// - hold 3-bit drive strength code, factory value 101.
// - wrap enable bit selects wrapped (1) or linear (0) reads, default 0.
// - 2-bit wrap length picks 8, 16, 32 or 64 byte groups, default 00.
// - wrapped reads cycle inside the aligned group; linear reads just increment.
// - wrap length only matters while wrap is enabled.
// - ecc mode bit: 0 single correct, 1 also double detect; factory 1.
// - ecc mode also picks whether double errors set the status flag.
// - sleep bit chooses standby or deep power down after power-on.
// - deep power down left on chip select pulse or hardware reset.
// - sleep bit writable in nonvolatile copy only; volatile copy read-only.
// - link check control bit 0 disables when 1, resets 0, upper bits zero.
// - read-only 32-bit link check result, resets to all ones.
// - read-only 32-bit array check result, resets to zero.
// - ecc over 16-byte units; status follows the unit last read.
// - double error flag sets on detection, sticky until clear command; hardware reset also clears it here.
// - single error flag sets on corrected error, sticky until clear command; hardware reset also clears it here.
`timescale 1ns/1ps
`include "frw_params.svh"
`default_nettype none
module frw_regs
    import frw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic hw_reset_n,
    input wire logic burst_start,
    input wire logic [31:0] start_addr,
    input wire logic ecc_single_evt,
    input wire logic ecc_double_evt,
    input wire logic clear_error_status_cmd,
    input wire logic link_crc_load,
    input wire logic [31:0] link_crc_value,
    input wire logic array_crc_load,
    input wire logic [31:0] array_crc_value,
    output logic [2:0] drive_strength_code,
    output logic wrap_read_enable,
    output logic [1:0] wrap_group_length,
    output logic ecc_mode_select,
    output logic ecc_record_double,
    output logic link_check_disable,
    output logic deep_power_down,
    output logic [31:0] read_addr,
    output logic [27:0] ecc_unit_index
);
    localparam frw_state_type FRW_RST = '{
        nv_cfg: `FRW_CFG_FACTORY,
        v_cfg: `FRW_CFG_FACTORY,
        crc_dis: 1'b0,
        lcrc: `FRW_LCRC_RST,
        acrc: `FRW_ACRC_RST,
        dbl: 1'b0,
        sgl: 1'b0,
        pwr: FRW_PWR_INIT,
        addr: `FRW_ZERO32,
        burst: 1'b0,
        sck_s: `FRW_SYNC_LO3,
        cs_s: `FRW_SYNC_HI3,
        hwr_s: `FRW_SYNC_HI2,
        rdata: `FRW_ZERO32
    };

    frw_state_type st_reg;
    frw_state_type st_next;
    logic [7:0] a8;
    logic hit;
    logic acc;
    logic wr;
    logic sck_rise;
    logic cs_rise;
    logic cs_low;
    logic hw_rst;
    logic clr;
    logic wen;
    logic [6:0] grp;
    logic [31:0] mask;
    logic [31:0] incr;
    logic [31:0] rd_mux;

    assign a8 = paddr[`FRW_AW-1:0];
    assign acc = psel & penable;
    assign wr = acc & pwrite & hit;
    // edges come from the second and third flops; the first is left alone
    assign sck_rise = st_reg.sck_s[1] & ~st_reg.sck_s[2];
    assign cs_rise = st_reg.cs_s[1] & ~st_reg.cs_s[2];
    assign cs_low = ~st_reg.cs_s[1];
    assign hw_rst = ~st_reg.hwr_s[1];
    assign clr = clear_error_status_cmd;
    assign wen = st_reg.v_cfg[`FRW_B_WEN];

    // group size from the length field; mask only bites while wrap is on
    assign grp = `FRW_WRAP_BASE << st_reg.v_cfg[`FRW_B_WLEN_HI:`FRW_B_WLEN_LO];
    assign mask = 32'(grp) - `FRW_ONE32;
    assign incr = st_reg.addr + `FRW_ONE32;

    // address decode and read mux; unused bits stay zero
    always_comb
    begin
        hit = 1'b1;
        rd_mux = `FRW_ZERO32;
        case (a8)
            `FRW_OFS_NVCFG: rd_mux[`FRW_CFG_W-1:0] = st_reg.nv_cfg;
            `FRW_OFS_VCFG: rd_mux[`FRW_CFG_W-1:0] = st_reg.v_cfg;
            `FRW_OFS_CRCCTL: rd_mux[`FRW_B_CRCD] = st_reg.crc_dis;
            `FRW_OFS_LCRC: rd_mux = st_reg.lcrc;
            `FRW_OFS_ACRC: rd_mux = st_reg.acrc;
            `FRW_OFS_ESTAT:
            begin
                rd_mux[`FRW_B_DBL] = st_reg.dbl;
                rd_mux[`FRW_B_SGL] = st_reg.sgl;
            end
            default: hit = 1'b0;
        endcase
    end

    // whole next-state computation
    always_comb
    begin
        st_next = st_reg;
        st_next.sck_s = {st_reg.sck_s[1:0], sclk};
        st_next.cs_s = {st_reg.cs_s[1:0], chip_select_n};
        st_next.hwr_s = {st_reg.hwr_s[0], hw_reset_n};

        // read data captured in setup so prdata is a flop with zero wait
        if (psel & ~penable & ~pwrite)
        begin
            st_next.rdata = rd_mux;
        end

        if (wr)
        begin
            case (a8)
                `FRW_OFS_NVCFG: st_next.nv_cfg = pwdata[`FRW_CFG_W-1:0];
                `FRW_OFS_VCFG:
                begin
                    // sleep bit of the volatile copy cannot be written, so it keeps its value
                    st_next.v_cfg[`FRW_B_DRV_HI:`FRW_B_DRV_LO] = pwdata[`FRW_B_DRV_HI:`FRW_B_DRV_LO];
                    st_next.v_cfg[`FRW_B_WEN] = pwdata[`FRW_B_WEN];
                    st_next.v_cfg[`FRW_B_ECC] = pwdata[`FRW_B_ECC];
                    st_next.v_cfg[`FRW_B_WLEN_HI:`FRW_B_WLEN_LO] = pwdata[`FRW_B_WLEN_HI:`FRW_B_WLEN_LO];
                end
                `FRW_OFS_CRCCTL: st_next.crc_dis = pwdata[`FRW_B_CRCD];
                default: st_next.crc_dis = st_reg.crc_dis;
            endcase
        end

        // check values come from the crc engines outside this block
        if (link_crc_load)
        begin
            st_next.lcrc = link_crc_value;
        end
        if (array_crc_load)
        begin
            st_next.acrc = array_crc_value;
        end

        // read address walk, one step per serial clock rise in a frame
        if (burst_start)
        begin
            st_next.addr = start_addr;
            st_next.burst = 1'b1;
        end
        else if (st_reg.burst & sck_rise & cs_low)
        begin
            if (wen)
            begin
                st_next.addr = (st_reg.addr & ~mask) | (incr & mask);
            end
            else
            begin
                st_next.addr = incr;
            end
        end
        else if (cs_rise)
        begin
            st_next.burst = 1'b0;
        end

        // sticky flags: a new event beats a clear in the same cycle
        st_next.dbl = (st_reg.dbl & ~clr) | (ecc_double_evt & st_reg.v_cfg[`FRW_B_ECC]);
        st_next.sgl = (st_reg.sgl & ~clr) | ecc_single_evt;

        // power state after reset release
        case (st_reg.pwr)
            FRW_PWR_INIT:
            begin
                if (st_reg.nv_cfg[`FRW_B_SLP])
                begin
                    st_next.pwr = FRW_PWR_DPD;
                end
                else
                begin
                    st_next.pwr = FRW_PWR_STBY;
                end
            end
            FRW_PWR_STBY: st_next.pwr = FRW_PWR_STBY;
            FRW_PWR_DPD:
            begin
                if (cs_rise | hw_rst)
                begin
                    st_next.pwr = FRW_PWR_STBY;
                end
            end
            default: st_next.pwr = FRW_PWR_INIT;
        endcase

        // hardware reset pin: reload volatile copy, drop flags
        if (hw_rst)
        begin
            st_next.v_cfg = st_reg.nv_cfg;
            st_next.crc_dis = 1'b0;
            st_next.dbl = 1'b0;
            st_next.sgl = 1'b0;
            st_next.burst = 1'b0;
        end
    end

    // power-on reset loads factory values into both copies
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= FRW_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs; volatile copy drives the rest of the device
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata = st_reg.rdata;
    assign drive_strength_code = st_reg.v_cfg[`FRW_B_DRV_HI:`FRW_B_DRV_LO];
    assign wrap_read_enable = wen;
    assign wrap_group_length = st_reg.v_cfg[`FRW_B_WLEN_HI:`FRW_B_WLEN_LO];
    assign ecc_mode_select = st_reg.v_cfg[`FRW_B_ECC];
    assign ecc_record_double = st_reg.v_cfg[`FRW_B_ECC];
    assign link_check_disable = st_reg.crc_dis;
    assign deep_power_down = (st_reg.pwr == FRW_PWR_DPD);
    assign read_addr = st_reg.addr;
    // unit index of the byte being read, so status maps to that unit
    assign ecc_unit_index = st_reg.addr[31:`FRW_UNIT_SHIFT];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // a step of the walk while wrapping never leaves its aligned 64-byte block
    a_wrap_in_group: assert property (st_reg.burst && sck_rise && cs_low && wen && !burst_start && !hw_rst
        |=> st_reg.addr[31:6] == $past(st_reg.addr[31:6]))
        else $error("wrap left group");

    a_linear_step: assert property (st_reg.burst && sck_rise && cs_low && !wen && !burst_start && !hw_rst
        |=> st_reg.addr == $past(st_reg.addr) + 32'h00000001)
        else $error("linear step wrong");

    a_wrap_len8: assert property (st_reg.burst && sck_rise && cs_low && wen && !burst_start
        && st_reg.v_cfg[1:0] == 2'h0 && !hw_rst
        |=> st_reg.addr[2:0] == $past(st_reg.addr[2:0]) + 3'h1
        && st_reg.addr[31:3] == $past(st_reg.addr[31:3]))
        else $error("8 byte wrap wrong");

    a_dbl_gated: assert property (!st_reg.v_cfg[`FRW_B_ECC] && !st_reg.dbl |=> !st_reg.dbl)
        else $error("double flag set without detection");

    a_dbl_sticky: assert property (st_reg.dbl && !clr && !hw_rst |=> st_reg.dbl)
        else $error("double flag lost");

    a_sgl_set_wins: assert property (ecc_single_evt && !hw_rst |=> st_reg.sgl)
        else $error("single flag missed");

    a_sleep_ro: assert property (wr && a8 == `FRW_OFS_VCFG && !hw_rst
        |=> st_reg.v_cfg[`FRW_B_SLP] == $past(st_reg.v_cfg[`FRW_B_SLP]))
        else $error("volatile sleep bit written");

    a_pwr_entry: assert property (st_reg.pwr == FRW_PWR_INIT
        |=> deep_power_down == $past(st_reg.nv_cfg[`FRW_B_SLP]))
        else $error("wrong power-on state");

    a_dpd_exit: assert property (st_reg.pwr == FRW_PWR_DPD && cs_rise |=> st_reg.pwr == FRW_PWR_STBY)
        else $error("no wake from chip select");

    a_crc_upper0: assert property (psel && !penable && !pwrite && a8 == `FRW_OFS_CRCCTL
        |=> prdata[31:1] == 31'h00000000)
        else $error("crc control upper bits set");

    a_hwr_reload: assert property (hw_rst |=> st_reg.v_cfg == $past(st_reg.nv_cfg)
        && !st_reg.dbl)
        else $error("hw reset reload failed");

    // a burst start takes the start address whatever the walk was doing
    a_burst_load: assert property (burst_start && !hw_rst
        |=> st_reg.addr == $past(start_addr) && st_reg.burst)
        else $error("burst start address not taken");

    // chip select rising closes the frame so stray clock rises cannot step
    a_frame_end: assert property (cs_rise && !burst_start && !hw_rst |=> !st_reg.burst)
        else $error("burst survived frame end");

    // with the largest group a step moves only the low six address bits
    a_wrap_len64: assert property (st_reg.burst && sck_rise && cs_low && wen && !burst_start
        && st_reg.v_cfg[`FRW_B_WLEN_HI:`FRW_B_WLEN_LO] == 2'h3 && !hw_rst
        |=> st_reg.addr[5:0] == $past(st_reg.addr[5:0]) + 6'h01
        && st_reg.addr[31:6] == $past(st_reg.addr[31:6]))
        else $error("64 byte wrap wrong");

    // a double error under double detection must be recorded
    a_dbl_set: assert property (ecc_double_evt && st_reg.v_cfg[`FRW_B_ECC] && !hw_rst
        |=> st_reg.dbl)
        else $error("double flag missed");

    // single flag holds until a clear or a reset
    a_sgl_sticky: assert property (st_reg.sgl && !clr && !hw_rst |=> st_reg.sgl)
        else $error("single flag lost");

    // a clear with no new event leaves both flags low
    a_flag_clear: assert property (clr && !ecc_single_evt && !ecc_double_evt
        |=> !st_reg.sgl && !st_reg.dbl)
        else $error("flags not cleared");

    // check values follow their engines and ignore bus writes
    a_lcrc_load: assert property (link_crc_load |=> st_reg.lcrc == $past(link_crc_value))
        else $error("link check value not loaded");

    a_acrc_load: assert property (array_crc_load |=> st_reg.acrc == $past(array_crc_value))
        else $error("array check value not loaded");

    a_lcrc_ro: assert property (wr && a8 == `FRW_OFS_LCRC && !link_crc_load
        |=> st_reg.lcrc == $past(st_reg.lcrc))
        else $error("link check value written");

    a_acrc_ro: assert property (wr && a8 == `FRW_OFS_ACRC && !array_crc_load
        |=> st_reg.acrc == $past(st_reg.acrc))
        else $error("array check value written");

    // the power-on decision is taken once; init is never re-entered
    a_pwr_once: assert property (st_reg.pwr != FRW_PWR_INIT |=> st_reg.pwr != FRW_PWR_INIT)
        else $error("power state back to init");

    // unmapped reads return zero along with the error
    a_unmapped_zero: assert property (psel && !penable && !pwrite && !hit
        |=> prdata == `FRW_ZERO32)
        else $error("unmapped read not zero");

    // a nonvolatile write lands whole, sleep bit included
    a_nv_write: assert property (wr && a8 == `FRW_OFS_NVCFG
        |=> st_reg.nv_cfg == $past(pwdata[`FRW_CFG_W-1:0]))
        else $error("nonvolatile copy not written");

    // a volatile write changes drive and ecc mode like every field but the sleep bit
    a_vcfg_write: assert property (wr && a8 == `FRW_OFS_VCFG && !hw_rst
        |=> st_reg.v_cfg[`FRW_B_DRV_HI:`FRW_B_DRV_LO] == $past(pwdata[`FRW_B_DRV_HI:`FRW_B_DRV_LO])
        && st_reg.v_cfg[`FRW_B_ECC] == $past(pwdata[`FRW_B_ECC]))
        else $error("volatile copy not written");

    // hardware reset drops the crc disable bit back to its reset value
    a_crc_hw_clear: assert property (hw_rst |=> !st_reg.crc_dis)
        else $error("crc disable survived reset");
endmodule // frw_regs
`default_nettype wire

// ### verif/frw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host end of the serial link; its clock stands low outside frames
module frw_host_model
(
    input wire logic pclk,
    output logic sclk,
    output logic chip_select_n
);
    initial
    begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
    end

    // one frame of n clock rises at a 160 ns period, closed by a select rise
    task automatic frame(input int n);
        @(posedge pclk);
        chip_select_n <= 1'b0;
        repeat (4) @(posedge pclk);
        repeat (n)
        begin
            repeat (8) @(posedge pclk);
            sclk <= 1'b1;
            repeat (8) @(posedge pclk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        chip_select_n <= 1'b1;
    endtask
endmodule // frw_host_model
`default_nettype wire

// ### verif/frw_regs_tb_top.sv
`timescale 1ns/1ps
`include "frw_params.svh"
`default_nettype none
module frw_regs_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sclk, chip_select_n, hw_reset_n, er;
    logic wrap_read_enable, ecc_mode_select, ecc_record_double, link_check_disable, deep_power_down;
    logic [1:0] wrap_group_length;
    logic [2:0] drive_strength_code;
    logic [5:0] ev;
    logic [27:0] ecc_unit_index;
    logic [31:0] paddr, pwdata, prdata, start_addr, link_crc_value, array_crc_value, read_addr, rd, ea;
    int n_mismatch = 0;
    int checks_done = 0;

    frw_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sclk, .chip_select_n, .hw_reset_n, .burst_start(ev[5]), .start_addr, .ecc_single_evt(ev[0]),
        .ecc_double_evt(ev[1]), .clear_error_status_cmd(ev[2]), .link_crc_load(ev[3]), .link_crc_value,
        .array_crc_load(ev[4]), .array_crc_value, .drive_strength_code, .wrap_read_enable,
        .wrap_group_length, .ecc_mode_select, .ecc_record_double, .link_check_disable, .deep_power_down,
        .read_addr, .ecc_unit_index);
    frw_host_model u_host (.pclk, .sclk, .chip_select_n);

    always #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; data taken at the edge that sees pready, only the watchdog ends a wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle pulse on an event input
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev <= 6'h00;
    endtask

    // expected next read address: when wrapping, group base plus the offset stepped modulo the group size; otherwise address plus one
    function automatic logic [31:0] nxt(input logic [31:0] a, input logic w, input logic [1:0] l);
        logic [31:0] g;
        g = 32'h00000008 << l;
        return w ? (a - (a % g)) + (((a % g) + 32'h00000001) % g) : a + 32'h00000001;
    endfunction

    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #300000;
        n_mismatch++;
        results;
    end

    initial
    begin
        logic [7:0] ofs [6] = '{`FRW_OFS_NVCFG, `FRW_OFS_VCFG, `FRW_OFS_CRCCTL, `FRW_OFS_LCRC, `FRW_OFS_ACRC,
            `FRW_OFS_ESTAT};
        logic [31:0] rst [6] = '{32'ha8, 32'ha8, 32'h0, 32'hffffffff, 32'h0, 32'h0};
        logic [31:0] starts [5] = '{32'h107, 32'h20c, 32'h31e, 32'h43e, 32'h53e};
        logic [7:0] c;
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, er} = 4'h0;
        {paddr, pwdata, start_addr, rd} = {4{32'h00000000}};
        link_crc_value = 32'h5a5a0ff0;
        array_crc_value = 32'h0123abcd;
        hw_reset_n = 1'b1;
        ev = 6'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rd, rst[i]);
        end
        chk(drive_strength_code, 32'h5);
        chk(ecc_record_double, 32'h1);
        chk(deep_power_down, 32'h0);
        $display("test reset values done");
        apb(1'b1, `FRW_OFS_VCFG, 32'hff);
        apb(1'b0, `FRW_OFS_VCFG, 32'h0);
        chk(rd, 32'hfb);
        apb(1'b1, `FRW_OFS_NVCFG, 32'h04);
        apb(1'b0, `FRW_OFS_NVCFG, 32'h0);
        chk(rd, 32'h04);
        apb(1'b1, `FRW_OFS_CRCCTL, 32'h01);
        apb(1'b0, `FRW_OFS_CRCCTL, 32'h0);
        chk({rd[30:0], link_check_disable}, 32'h3);
        apb(1'b1, `FRW_OFS_LCRC, 32'h0);
        apb(1'b0, `FRW_OFS_LCRC, 32'h0);
        chk(rd, 32'hffffffff);
        apb(1'b0, 8'h18, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        $display("test access kinds done");
        pulse(0);
        @(posedge pclk);
        hw_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        hw_reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, `FRW_OFS_VCFG, 32'h0);
        chk(rd, 32'h04);
        apb(1'b0, `FRW_OFS_ESTAT, 32'h0);
        chk(rd, 32'h0);
        chk(link_check_disable, 32'h0);
        chk(deep_power_down, 32'h0);
        $display("test hardware reset done");
        for (int l = 0; l < 5; l++)
        begin
            c = (l < 4) ? (8'hb8 | 8'(l)) : 8'hab;
            apb(1'b1, `FRW_OFS_VCFG, {24'h000000, c});
            start_addr <= starts[l];
            pulse(5);
            @(posedge pclk);
            chk(read_addr, starts[l]);
            chk({wrap_read_enable, wrap_group_length}, {c[4], c[1:0]});
            u_host.frame(9);
            ea = starts[l];
            repeat (9) ea = nxt(ea, l < 4, 2'(l));
            repeat (6) @(posedge pclk);
            chk(read_addr, ea);
            chk(ecc_unit_index, {4'h0, ea[31:4]});
        end
        $display("test wrap bursts done");
        pulse(0);
        apb(1'b0, `FRW_OFS_ESTAT, 32'h0);
        chk(rd, 32'h08);
        pulse(1);
        apb(1'b0, `FRW_OFS_ESTAT, 32'h0);
        chk(rd, 32'h18);
        // event and clear in one cycle: the new single error must win over the clear
        @(posedge pclk);
        ev <= 6'h05;
        @(posedge pclk);
        ev <= 6'h00;
        apb(1'b0, `FRW_OFS_ESTAT, 32'h0);
        chk(rd, 32'h08);
        pulse(2);
        apb(1'b0, `FRW_OFS_ESTAT, 32'h0);
        chk(rd, 32'h0);
        // no array data is relied on after the mode change, so none needs rewriting
        apb(1'b1, `FRW_OFS_VCFG, 32'ha0);
        @(posedge pclk);
        chk(ecc_mode_select, 32'h0);
        pulse(1);
        apb(1'b0, `FRW_OFS_ESTAT, 32'h0);
        chk(rd, 32'h0);
        $display("test error flags done");
        pulse(3);
        pulse(4);
        apb(1'b0, `FRW_OFS_LCRC, 32'h0);
        chk(rd, link_crc_value);
        apb(1'b0, `FRW_OFS_ACRC, 32'h0);
        chk(rd, array_crc_value);
        $display("test check results done");
        results;
    end
endmodule // frw_regs_tb_top
`default_nettype wire
